// ==== iod_defines.svh ====
// Offsets, field positions and reset values of the I/O register decode block.
`ifndef IOD_DEFINES_SVH
`define IOD_DEFINES_SVH

// ------------------------------------------------------------------
// Address map.
// ------------------------------------------------------------------
`define IOD_IO_TO_DATA_OFS 8'h20
`define IOD_BIT_IO_LAST 6'h1F
`define IOD_EXT_FIRST 8'h60
`define IOD_EXT_LAST 8'hFF
`define IOD_ADR_T3_CMPB_LOW 8'h9A
`define IOD_ADR_T3_CMPB_HIGH 8'h9B
`define IOD_ADR_T2_CTRL_A 8'hB0
`define IOD_ADR_T2_CTRL_B 8'hB1
`define IOD_ADR_T2_COUNT 8'hB2
`define IOD_ADR_T2_CMP_A 8'hB3
`define IOD_ADR_T2_CMP_B 8'hB4
`define IOD_ADR_ASYNC_STATUS 8'hB6
`define IOD_ADR_TW_BIT_RATE 8'hB8
`define IOD_ADR_TW_STATUS 8'hB9
`define IOD_ADR_TW_OWN_ADDR 8'hBA
`define IOD_ADR_TW_DATA 8'hBB
`define IOD_ADR_TW_CONTROL 8'hBC
`define IOD_ADR_TW_ADDR_MASK 8'hBD

// ------------------------------------------------------------------
// Writable and read-only bit masks; bits outside a writable mask read as zero or come from the peripheral.
// ------------------------------------------------------------------
`define IOD_MSK_T2_CTRL_A 8'hF3
`define IOD_MSK_T2_CTRL_B 8'h0F
`define IOD_POS_T2_FORCE_A 7
`define IOD_POS_T2_FORCE_B 6
`define IOD_MSK_ASYNC_RW 8'h60
`define IOD_MSK_ASYNC_RO 8'h1F
`define IOD_MSK_TW_STAT_RW 8'h03
`define IOD_MSK_TW_STAT_RO 8'hF8
`define IOD_MSK_TW_CTRL_RW 8'h75
`define IOD_POS_TW_INT 7
`define IOD_POS_TW_COLLIDE 3
`define IOD_MSK_TW_ADDR_MASK 8'hFE

// ------------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------------
`define IOD_RST_REG 8'h00
`define IOD_RST_TW_BIT_RATE 8'h00
`define IOD_RST_TW_DATA 8'hFF
`define IOD_RST_TW_OWN_ADDR 8'hFE

`endif

// ==== iod_pkg.sv ====
// Types shared by the I/O register decode block.
package iod_pkg;

    // Access kinds issued by the core.
    typedef enum logic [7:0] {
        IOD_OP_PORT_READ = 8'h01,
        IOD_OP_PORT_WRITE = 8'h02,
        IOD_OP_BIT_SET = 8'h04,
        IOD_OP_BIT_CLEAR = 8'h08,
        IOD_OP_SKIP_ONE = 8'h10,
        IOD_OP_SKIP_ZERO = 8'h20,
        IOD_OP_MEM_READ = 8'h40,
        IOD_OP_MEM_WRITE = 8'h80
    } iod_op_type;

endpackage : iod_pkg

// ==== iod_bit_alu.sv ====
// Single-bit modify and test unit used by the bit instructions.
`timescale 1ns/10ps
module iod_bit_alu
    import iod_pkg::*;
(
    // Operation.
    input wire iod_op_type op,
    input wire logic [2:0] bit_sel,
    // Register value read back.
    input wire logic [7:0] read_val,
    // Results.
    output logic [7:0] modify_val,
    output logic test_hit
);

    // One-hot mask of the chosen bit.
    wire logic [7:0] bit_mask = 8'h01 << bit_sel;
    // The whole register is written back, so flags read as one are rewritten as one.
    wire logic [7:0] set_val = read_val | bit_mask;
    wire logic [7:0] clr_val = read_val & ~bit_mask;
    // Value of the tested bit.
    wire logic bit_val = read_val[bit_sel];

    // Modify value for set or clear; other operations pass the value through.
    assign modify_val = (op == IOD_OP_BIT_SET) ? set_val : (op == IOD_OP_BIT_CLEAR) ? clr_val : read_val;
    // Skip condition for the two skip instructions.
    assign test_hit = ((op == IOD_OP_SKIP_ONE) & bit_val) | ((op == IOD_OP_SKIP_ZERO) & ~bit_val);

endmodule : iod_bit_alu

// ==== iod_regbank.sv ====
// I/O register space decode for the two-wire, timer 2 and timer 3 compare B registers.
//
// Notes on behaviour
// - Bit set/clear only at I/O addresses 0-31.
// - Skip instructions test bits in that range.
// - Some flags clear on writing one.
// - Bit set/clear rewrites whole register, clearing flags.
// - Port instructions reach I/O addresses 0 to 63.
// - Data address equals I/O address plus 32.
// - Region 0x60-0xFF reachable only by memory ops.
`timescale 1ns/10ps
`include "iod_defines.svh"
module iod_regbank
    import iod_pkg::*;
(
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    // Core access request.
    input wire logic op_valid,
    input wire iod_op_type op_code,
    input wire logic [5:0] io_addr,
    input wire logic [15:0] mem_addr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] wdata,
    // Core access answer.
    output logic [7:0] rdata_reg,
    output logic skip_reg,
    output logic done_reg,
    output logic refused_reg,
    // Peripheral status inputs, same clock domain.
    input wire logic tw_int_set,
    input wire logic tw_collide,
    input wire logic [4:0] tw_state,
    input wire logic [4:0] async_busy,
    // Register contents towards the peripherals.
    output logic [15:0] t3_cmp_b,
    output logic [7:0] t2_ctrl_a,
    output logic [7:0] t2_ctrl_b,
    output logic [7:0] t2_count,
    output logic t2_count_load,
    output logic t2_force_a,
    output logic t2_force_b,
    output logic [7:0] t2_cmp_a,
    output logic [7:0] t2_cmp_b,
    output logic [7:0] async_ctrl,
    output logic [7:0] tw_bit_rate,
    output logic [7:0] tw_prescale,
    output logic [7:0] tw_own_addr,
    output logic [7:0] tw_data,
    output logic [7:0] tw_control,
    output logic tw_data_wr,
    output logic [7:0] tw_addr_mask
);

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------

    // Merges a written value into a register, keeping only writable bits.
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v, input logic [7:0] msk);
        merge = (old_v & ~msk) | (new_v & msk);
    endfunction : merge

    // Converts an I/O address into its data-space address.
    function automatic logic [7:0] io_to_data(input logic [5:0] a);
        io_to_data = {2'b00, a} + `IOD_IO_TO_DATA_OFS;
    endfunction : io_to_data

    // ------------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------------
    logic [7:0] t3_cmpb_lo_reg; // Timer 3 compare B low byte.
    logic [7:0] t3_cmpb_hi_reg; // Timer 3 compare B high byte.
    logic [7:0] t2_ctrl_a_reg; // Timer 2 control A.
    logic [7:0] t2_ctrl_b_reg; // Timer 2 control B, stored bits only.
    logic [7:0] t2_count_reg; // Timer 2 count.
    logic [7:0] t2_cmp_a_reg; // Timer 2 compare A.
    logic [7:0] t2_cmp_b_reg; // Timer 2 compare B.
    logic [7:0] async_reg; // Asynchronous status, writable bits.
    logic [7:0] tw_rate_reg; // Two-wire bit rate.
    logic [7:0] tw_stat_reg; // Two-wire status, prescaler bits.
    logic [7:0] tw_own_reg; // Two-wire own address.
    logic [7:0] tw_data_reg; // Two-wire data.
    logic [7:0] tw_ctrl_reg; // Two-wire control, writable bits.
    logic tw_int_reg; // Two-wire interrupt flag.
    logic [7:0] tw_amask_reg; // Two-wire address mask.
    logic t2_load_reg; // Count written pulse.
    logic force_a_reg; // Force compare A pulse.
    logic force_b_reg; // Force compare B pulse.
    logic tw_dwr_reg; // Data written pulse.

    // ------------------------------------------------------------------
    // Operation decode.
    // ------------------------------------------------------------------
    wire logic is_port = (op_code == IOD_OP_PORT_READ) | (op_code == IOD_OP_PORT_WRITE);
    wire logic is_bit_mod = (op_code == IOD_OP_BIT_SET) | (op_code == IOD_OP_BIT_CLEAR);
    wire logic is_skip = (op_code == IOD_OP_SKIP_ONE) | (op_code == IOD_OP_SKIP_ZERO);
    wire logic is_mem = (op_code == IOD_OP_MEM_READ) | (op_code == IOD_OP_MEM_WRITE);
    // Bit instructions are refused above the bit-addressable range.
    wire logic bit_range_ok = (io_addr <= `IOD_BIT_IO_LAST);
    wire logic bit_ok = (is_bit_mod | is_skip) & bit_range_ok;
    wire logic accepted = op_valid & (is_port | is_mem | bit_ok);
    wire logic refuse = op_valid & (is_bit_mod | is_skip) & ~bit_range_ok;
    // Port and bit instructions carry six address bits, so they stop at data 0x5F.
    wire logic [7:0] io_daddr = io_to_data(io_addr);
    // Memory accesses outside the lower 256 bytes never hit this block.
    wire logic mem_low = (mem_addr[15:8] == 8'h00);
    // The extended region is reached only through the memory path.
    wire logic [7:0] daddr = is_mem ? mem_addr[7:0] : io_daddr;
    wire logic addr_hit = is_mem ? mem_low : 1'b1;
    wire logic do_write = accepted & addr_hit & ((op_code == IOD_OP_PORT_WRITE) | (op_code == IOD_OP_MEM_WRITE) | is_bit_mod);

    // ------------------------------------------------------------------
    // Read selection; reserved locations and reserved bits read zero.
    // ------------------------------------------------------------------
    wire logic [7:0] tw_ctrl_view = tw_ctrl_reg | ({7'h00, tw_int_reg} << `IOD_POS_TW_INT)
                                  | ({7'h00, tw_collide} << `IOD_POS_TW_COLLIDE);
    wire logic [7:0] tw_stat_view = tw_stat_reg | ({tw_state, 3'b000} & `IOD_MSK_TW_STAT_RO);
    wire logic [7:0] async_view = async_reg | ({3'b000, async_busy} & `IOD_MSK_ASYNC_RO);
    logic [7:0] read_val;

    // Selects the addressed register value.
    always_comb begin
        read_val = 8'h00;
        if (addr_hit) begin
            case (daddr)
                `IOD_ADR_T3_CMPB_LOW: read_val = t3_cmpb_lo_reg;
                `IOD_ADR_T3_CMPB_HIGH: read_val = t3_cmpb_hi_reg;
                `IOD_ADR_T2_CTRL_A: read_val = t2_ctrl_a_reg;
                `IOD_ADR_T2_CTRL_B: read_val = t2_ctrl_b_reg;
                `IOD_ADR_T2_COUNT: read_val = t2_count_reg;
                `IOD_ADR_T2_CMP_A: read_val = t2_cmp_a_reg;
                `IOD_ADR_T2_CMP_B: read_val = t2_cmp_b_reg;
                `IOD_ADR_ASYNC_STATUS: read_val = async_view;
                `IOD_ADR_TW_BIT_RATE: read_val = tw_rate_reg;
                `IOD_ADR_TW_STATUS: read_val = tw_stat_view;
                `IOD_ADR_TW_OWN_ADDR: read_val = tw_own_reg;
                `IOD_ADR_TW_DATA: read_val = tw_data_reg;
                `IOD_ADR_TW_CONTROL: read_val = tw_ctrl_view;
                `IOD_ADR_TW_ADDR_MASK: read_val = tw_amask_reg;
                default: read_val = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bit modify and test.
    // ------------------------------------------------------------------
    logic [7:0] modify_val;
    logic test_hit;

    iod_bit_alu u_bit_alu (
        .op(op_code),
        .bit_sel(bit_sel),
        .read_val(read_val),
        .modify_val(modify_val),
        .test_hit(test_hit)
    );

    // Write data: plain data for port and memory writes, read-modify-write for bit ops.
    wire logic [7:0] wr_val = is_bit_mod ? modify_val : wdata;
    // Per-register write enables; unmapped addresses decode to nothing.
    wire logic we_t3l = do_write & (daddr == `IOD_ADR_T3_CMPB_LOW);
    wire logic we_t3h = do_write & (daddr == `IOD_ADR_T3_CMPB_HIGH);
    wire logic we_t2a = do_write & (daddr == `IOD_ADR_T2_CTRL_A);
    wire logic we_t2b = do_write & (daddr == `IOD_ADR_T2_CTRL_B);
    wire logic we_t2c = do_write & (daddr == `IOD_ADR_T2_COUNT);
    wire logic we_t2ca = do_write & (daddr == `IOD_ADR_T2_CMP_A);
    wire logic we_t2cb = do_write & (daddr == `IOD_ADR_T2_CMP_B);
    wire logic we_as = do_write & (daddr == `IOD_ADR_ASYNC_STATUS);
    wire logic we_two_wire_bit_rate = do_write & (daddr == `IOD_ADR_TW_BIT_RATE);
    wire logic we_twst = do_write & (daddr == `IOD_ADR_TW_STATUS);
    wire logic we_twoa = do_write & (daddr == `IOD_ADR_TW_OWN_ADDR);
    wire logic we_twd = do_write & (daddr == `IOD_ADR_TW_DATA);
    wire logic we_twc = do_write & (daddr == `IOD_ADR_TW_CONTROL);
    wire logic we_twam = do_write & (daddr == `IOD_ADR_TW_ADDR_MASK);
    // Writing one clears the interrupt flag, a new event wins over the clear.
    wire logic tw_int_clr = we_twc & wr_val[`IOD_POS_TW_INT];
    wire logic tw_int_next = tw_int_set | (tw_int_reg & ~tw_int_clr);

    // ------------------------------------------------------------------
    // Storage update.
    // ------------------------------------------------------------------

    // Timer registers.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            t3_cmpb_lo_reg <= `IOD_RST_REG;
            t3_cmpb_hi_reg <= `IOD_RST_REG;
            t2_ctrl_a_reg <= `IOD_RST_REG;
            t2_ctrl_b_reg <= `IOD_RST_REG;
            t2_count_reg <= `IOD_RST_REG;
            t2_cmp_a_reg <= `IOD_RST_REG;
            t2_cmp_b_reg <= `IOD_RST_REG;
            async_reg <= `IOD_RST_REG;
        end else if (clk_en) begin
            if (we_t3l) t3_cmpb_lo_reg <= wr_val;
            if (we_t3h) t3_cmpb_hi_reg <= wr_val;
            if (we_t2a) t2_ctrl_a_reg <= merge(t2_ctrl_a_reg, wr_val, `IOD_MSK_T2_CTRL_A);
            if (we_t2b) t2_ctrl_b_reg <= merge(t2_ctrl_b_reg, wr_val, `IOD_MSK_T2_CTRL_B);
            if (we_t2c) t2_count_reg <= wr_val;
            if (we_t2ca) t2_cmp_a_reg <= wr_val;
            if (we_t2cb) t2_cmp_b_reg <= wr_val;
            if (we_as) async_reg <= merge(async_reg, wr_val, `IOD_MSK_ASYNC_RW);
        end
    end

    // Two-wire registers.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tw_rate_reg <= `IOD_RST_TW_BIT_RATE;
            tw_stat_reg <= `IOD_RST_REG;
            tw_own_reg <= `IOD_RST_TW_OWN_ADDR;
            tw_data_reg <= `IOD_RST_TW_DATA;
            tw_ctrl_reg <= `IOD_RST_REG;
            tw_int_reg <= 1'b0;
            tw_amask_reg <= `IOD_RST_REG;
        end else if (clk_en) begin
            if (we_two_wire_bit_rate) tw_rate_reg <= wr_val;
            if (we_twst) tw_stat_reg <= merge(tw_stat_reg, wr_val, `IOD_MSK_TW_STAT_RW);
            if (we_twoa) tw_own_reg <= wr_val;
            if (we_twd) tw_data_reg <= wr_val;
            if (we_twc) tw_ctrl_reg <= merge(tw_ctrl_reg, wr_val, `IOD_MSK_TW_CTRL_RW);
            tw_int_reg <= tw_int_next;
            if (we_twam) tw_amask_reg <= merge(tw_amask_reg, wr_val, `IOD_MSK_TW_ADDR_MASK);
        end
    end

    // Answer to the core and write strobes towards the peripherals.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
            skip_reg <= 1'b0;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            t2_load_reg <= 1'b0;
            force_a_reg <= 1'b0;
            force_b_reg <= 1'b0;
            tw_dwr_reg <= 1'b0;
        end else if (clk_en) begin
            rdata_reg <= accepted ? read_val : 8'h00;
            skip_reg <= accepted & test_hit;
            done_reg <= op_valid;
            refused_reg <= refuse;
            t2_load_reg <= we_t2c;
            force_a_reg <= we_t2b & wr_val[`IOD_POS_T2_FORCE_A];
            force_b_reg <= we_t2b & wr_val[`IOD_POS_T2_FORCE_B];
            tw_dwr_reg <= we_twd;
        end
    end

    // ------------------------------------------------------------------
    // Outputs towards the peripherals.
    // ------------------------------------------------------------------
    assign t3_cmp_b = {t3_cmpb_hi_reg, t3_cmpb_lo_reg};
    assign t2_ctrl_a = t2_ctrl_a_reg;
    assign t2_ctrl_b = t2_ctrl_b_reg;
    assign t2_count = t2_count_reg;
    assign t2_count_load = t2_load_reg;
    assign t2_force_a = force_a_reg;
    assign t2_force_b = force_b_reg;
    assign t2_cmp_a = t2_cmp_a_reg;
    assign t2_cmp_b = t2_cmp_b_reg;
    assign async_ctrl = async_reg;
    assign tw_bit_rate = tw_rate_reg;
    assign tw_prescale = tw_stat_reg;
    assign tw_own_addr = tw_own_reg;
    assign tw_data = tw_data_reg;
    assign tw_control = tw_ctrl_view;
    assign tw_data_wr = tw_dwr_reg;
    assign tw_addr_mask = tw_amask_reg;

endmodule : iod_regbank

// ==== iod_regbank_properties.sv ====
// Concurrent checks on the ports of the I/O register decode block.
`timescale 1ns/10ps
module iod_regbank_properties
    import iod_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Core requests and peripheral flag input.
    input wire logic clk_en,
    input wire logic op_valid,
    input wire iod_op_type op_code,
    input wire logic [5:0] io_addr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] wdata,
    input wire logic tw_int_set,
    // Answers and register views.
    input wire logic [7:0] rdata_reg,
    input wire logic skip_reg,
    input wire logic done_reg,
    input wire logic refused_reg,
    input wire logic [7:0] tw_data,
    input wire logic tw_data_wr,
    input wire logic [7:0] tw_control
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // A request taken at this edge.
    wire logic take = clk_en && op_valid;
    // A bit set, bit clear or skip request.
    wire logic bit_op = take && (op_code[5:2] != 4'h0);
    // A store to the two-wire data register.
    sequence s_data_wr;
        take && op_code == IOD_OP_MEM_WRITE && mem_addr == 16'h00BB;
    endsequence
    // The stored byte shows with its write pulse.
    sequence s_data_seen;
        tw_data_wr && tw_data == $past(wdata);
    endsequence
    chk_done_after_req: assert property (take |=> done_reg) else $error("done missing");
    chk_no_done_idle: assert property (clk_en && !op_valid |=> !done_reg) else $error("stray done");
    chk_bit_refused: assert property (bit_op && io_addr > 6'h1F |=> refused_reg && !skip_reg && rdata_reg == 8'h00)
        else $error("bit op above range not refused");
    chk_bit_taken: assert property (bit_op && io_addr <= 6'h1F |=> !refused_reg) else $error("bit op refused");
    chk_skip_zero_bit: assert property (take && op_code == IOD_OP_SKIP_ZERO && io_addr <= 6'h1F |=> skip_reg)
        else $error("zero bit not skipped");
    chk_port_read_zero: assert property (take && op_code == IOD_OP_PORT_READ |=> rdata_reg == 8'h00)
        else $error("port read hit a register");
    chk_port_no_write: assert property (take && op_code inside {IOD_OP_PORT_WRITE, IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR}
        |=> !tw_data_wr && $stable(tw_data)) else $error("port op wrote data");
    chk_data_write: assert property (s_data_wr |=> s_data_seen) else $error("data store lost");
    chk_far_read_zero: assert property (take && op_code == IOD_OP_MEM_READ && mem_addr[15:8] != 8'h00
        |=> rdata_reg == 8'h00) else $error("far read not zero");
    chk_reserved_read: assert property (take && op_code == IOD_OP_MEM_READ && mem_addr == 16'h00B7
        |=> rdata_reg == 8'h00) else $error("reserved read not zero");
    chk_flag_clear: assert property (take && op_code == IOD_OP_MEM_WRITE && mem_addr == 16'h00BC && wdata[7]
        && !tw_int_set |=> !tw_control[7]) else $error("flag not cleared");
    chk_flag_set: assert property (clk_en && tw_int_set |=> tw_control[7]) else $error("flag not set");
endmodule : iod_regbank_properties

bind iod_regbank iod_regbank_properties chk_i (.mclk, .nrst, .clk_en, .op_valid, .op_code, .io_addr, .mem_addr,
    .wdata, .tw_int_set, .rdata_reg, .skip_reg, .done_reg, .refused_reg, .tw_data, .tw_data_wr, .tw_control);

// ==== iod_core_model.sv ====
// Behavioural model of the processor core issuing register accesses.
`timescale 1ns/10ps
module iod_core_model
    import iod_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Request lines.
    output logic op_valid,
    output iod_op_type op_code,
    output logic [5:0] io_addr,
    output logic [15:0] mem_addr,
    output logic [2:0] bit_sel,
    output logic [7:0] wdata,
    // Answer lines.
    input wire logic [7:0] rdata_reg,
    input wire logic skip_reg,
    input wire logic done_reg,
    input wire logic refused_reg
);
    // Reserved bits of each mapped register.
    function automatic logic [7:0] resv(input logic [15:0] a);
        case (a)
            16'h00B0: return 8'h0C;
            16'h00B1: return 8'h30;
            16'h00B6: return 8'h80;
            16'h00B9: return 8'h04;
            16'h00BC: return 8'h02;
            16'h00BD: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction : resv
    // Idle values at time zero.
    initial begin
        op_valid = 1'b0;
        op_code = IOD_OP_PORT_READ;
        io_addr = 6'h00;
        mem_addr = 16'h0000;
        bit_sel = 3'h0;
        wdata = 8'h00;
    end
    // One request: driven after an edge, taken at the next, answer read once it settles.
    task automatic access(input iod_op_type op, input logic [5:0] io, input logic [15:0] ma, input logic [2:0] bs,
        input logic [7:0] wd, input logic polite, output logic [7:0] rd, output logic sk, dn, rf);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= op;
        io_addr <= io;
        mem_addr <= ma;
        bit_sel <= bs;
        wdata <= polite ? (wd & ~resv(ma)) : wd;
        @(posedge mclk);
        op_valid <= 1'b0;
        io_addr <= ~io;
        mem_addr <= ~ma;
        wdata <= ~wd;
        #1;
        rd = rdata_reg;
        sk = skip_reg;
        dn = done_reg;
        rf = refused_reg;
    endtask : access
endmodule : iod_core_model

// ==== test_iod_regbank.sv ====
// Self-checking bench for the I/O register decode block.
`timescale 1ns/10ps
module test_iod_regbank;
    import iod_pkg::*;
    // Design ports.
    logic mclk, nrst, clk_en, op_valid, skip_reg, done_reg, refused_reg, tw_int_set, tw_collide;
    iod_op_type op_code, op;
    logic [5:0] io_addr, io;
    logic [15:0] mem_addr, t3_cmp_b;
    logic [2:0] bit_sel;
    logic [4:0] tw_state, async_busy;
    logic [7:0] wdata, rdata_reg, t2_ctrl_a, t2_ctrl_b, t2_count, t2_cmp_a, t2_cmp_b, async_ctrl, tw_bit_rate;
    logic [7:0] tw_prescale, tw_own_addr, tw_data, tw_control, tw_addr_mask;
    logic t2_count_load, t2_force_a, t2_force_b, tw_data_wr;
    // Bench state.
    int err_count = 0, tests_run = 0, seed = 80820;
    logic flag, sk, dn, rf;
    logic [7:0] rd, a, w, tdat, pexp;
    logic [7:0] adr_tab [18] = '{8'h9A, 8'h9B, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB6, 8'hB8, 8'hB9, 8'hBA,
        8'hBB, 8'hBC, 8'hBD, 8'hB5, 8'hB7, 8'hBE, 8'h9C};
    iod_op_type op_tab [6] = '{IOD_OP_PORT_READ, IOD_OP_PORT_WRITE, IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR,
        IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO};
    iod_regbank uut (.*);
    iod_core_model core (.*);
    // Expected read view of a data address after writing w.
    function automatic logic [7:0] view(input logic [7:0] ad, input logic [7:0] v);
        case (ad)
            8'hB0: return v & 8'hF3;
            8'hB1: return v & 8'h0F;
            8'hB6: return (v & 8'h60) | {3'h0, async_busy};
            8'hB9: return {tw_state, 1'b0, v[1:0]};
            8'hBC: return {flag, v[6:4], tw_collide, v[2], 1'b0, v[0]};
            8'hBD: return v & 8'hFE;
            8'h9A, 8'h9B, 8'hB2, 8'hB3, 8'hB4, 8'hB8, 8'hBA, 8'hBB: return v;
            default: return 8'h00;
        endcase
    endfunction : view
    // Output port that carries the register at a data address; reserved addresses give zero.
    function automatic logic [7:0] port_of(input logic [7:0] ad);
        case (ad)
            8'h9A: return t3_cmp_b[7:0];
            8'h9B: return t3_cmp_b[15:8];
            8'hB0: return t2_ctrl_a;
            8'hB1: return t2_ctrl_b;
            8'hB2: return t2_count;
            8'hB3: return t2_cmp_a;
            8'hB4: return t2_cmp_b;
            8'hB6: return async_ctrl;
            8'hB8: return tw_bit_rate;
            8'hB9: return tw_prescale;
            8'hBA: return tw_own_addr;
            8'hBB: return tw_data;
            8'hBC: return tw_control;
            8'hBD: return tw_addr_mask;
            default: return 8'h00;
        endcase
    endfunction : port_of
    // Compare and count.
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Print the verdict and stop.
    task end_sim;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Free-running 200 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Cut a hang short.
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        end_sim();
    end
    // Main sequence.
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        tw_int_set = 1'b0;
        tw_collide = 1'b0;
        tw_state = 5'h00;
        async_busy = 5'h00;
        flag = 1'b0;
        tdat = 8'hFF;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        check("tw_data", 8'hFF, tw_data);
        check("tw_own_addr", 8'hFE, tw_own_addr);
        check("zero regs", 8'h00, t3_cmp_b[7:0] | t3_cmp_b[15:8] | t2_ctrl_a | t2_count | tw_control | tw_bit_rate);
        // Random stores and loads over mapped and reserved addresses.
        for (int i = 0; i < 60; i++) begin
            a = adr_tab[$unsigned($random(seed)) % 18];
            @(posedge mclk);
            tw_state <= 5'($random(seed));
            async_busy <= 5'($random(seed));
            tw_collide <= 1'($random(seed));
            w = 8'($random(seed));
            core.access(IOD_OP_MEM_WRITE, 6'h00, {8'h00, a}, 3'h0, w, i[0], rd, sk, dn, rf);
            if (a == 8'hBB) tdat = w;
            // The register's own output and the one-cycle write pulses stand in this cycle.
            pexp = (a == 8'hB6) ? (w & 8'h60) : (a == 8'hB9) ? (w & 8'h03) : view(a, w);
            check("port view", pexp, port_of(a));
            check("pulses", {4'h0, a == 8'hBB, a == 8'hB2, a == 8'hB1 && w[7], a == 8'hB1 && w[6]},
                {4'h0, tw_data_wr, t2_count_load, t2_force_a, t2_force_b});
            core.access(IOD_OP_MEM_READ, 6'h00, {8'h00, a}, 3'h0, 8'h00, 1'b1, rd, sk, dn, rf);
            check("read back", view(a, w), rd);
            check("done", 8'h01, {7'h0, dn});
            core.access(IOD_OP_MEM_READ, 6'h00, {8'h01 | 8'($random(seed)), a}, 3'h0, 8'h00, 1'b1, rd, sk, dn, rf);
            check("far read", 8'h00, rd);
        end
        // Port and bit operations, edges of the bit range first.
        for (int i = 0; i < 48; i++) begin
            op = op_tab[i % 6];
            io = (i < 6) ? 6'h1F : (i < 12) ? 6'h20 : 6'($random(seed));
            w = 8'($random(seed));
            core.access(op, io, 16'h0000, w[2:0], w, 1'b1, rd, sk, dn, rf);
            check("refused", {7'h0, op[5:2] != 4'h0 && io > 6'h1F}, {7'h0, rf});
            check("skip", {7'h0, op == IOD_OP_SKIP_ZERO && io <= 6'h1F}, {7'h0, sk});
            check("port rdata", 8'h00, rd);
        end
        check("tw_data kept", tdat, tw_data);
        // Flag set by the interface, kept by a zero, cleared by a one.
        @(posedge mclk) tw_int_set <= 1'b1;
        @(posedge mclk) tw_int_set <= 1'b0;
        flag = 1'b1;
        core.access(IOD_OP_MEM_WRITE, 6'h00, 16'h00BC, 3'h0, 8'h04, 1'b1, rd, sk, dn, rf);
        core.access(IOD_OP_MEM_READ, 6'h00, 16'h00BC, 3'h0, 8'h00, 1'b1, rd, sk, dn, rf);
        check("flag kept", view(8'hBC, 8'h04), rd);
        core.access(IOD_OP_MEM_WRITE, 6'h00, 16'h00BC, 3'h0, 8'h80, 1'b1, rd, sk, dn, rf);
        flag = 1'b0;
        core.access(IOD_OP_MEM_READ, 6'h00, 16'h00BC, 3'h0, 8'h00, 1'b1, rd, sk, dn, rf);
        check("flag cleared", view(8'hBC, 8'h00), rd);
        // A store while the clock enable is low is not taken.
        @(posedge mclk) clk_en <= 1'b0;
        core.access(IOD_OP_MEM_WRITE, 6'h00, 16'h00BB, 3'h0, ~tdat, 1'b1, rd, sk, dn, rf);
        check("frozen done", 8'h00, {7'h0, dn});
        clk_en <= 1'b1;
        check("frozen", tdat, tw_data);
        end_sim();
    end
endmodule : test_iod_regbank
